// file: core/odcb_pkg.sv
// Constants, field layouts and carrier types of the output divider configuration bank
// What this block does
// - Eight-bit integer divider in bits 11:4; applied ratio is field plus one.
// - Fraction is 20 bits; its top four bits sit in bits 3:0 of the integer word.
// - The next word holds fraction bits 15:0, joined below the top four bits.
// - Channel 6 prescale code 000 divides by 2, 001 by 3, 111 by 1; rest reserved.
// - With the fraction path off, the channel 6 prescaler is bypassed regardless.
// - Bit 9 of the channel 6 mode word switches the fraction path on or off.
// - Bit 8 picks single-ended slew: zero normal, one slow.
// - Bit 6 enables the positive single-ended output, bit 7 the negative one.
// - Driver field bits 4:3: 00 or 01 differential, 10 single-ended, 11 HCSL.
// - Output field bits 2:1: off, clock, static low, static high.
// - Bit 0 picks supply range: zero 1.8 V, one 2.5/3.3 V.
package odcb_pkg;

    // ----------------------------------------------------------------
    // Bus and word sizes
    // ----------------------------------------------------------------
    localparam int ODCB_ADR_W = 8;
    localparam int ODCB_DAT_W = 32;
    localparam int ODCB_WORD_W = 16;

    // ----------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_CH5_INT = 6'h0d;
    localparam logic [5:0] IDX_CH5_FRAC = 6'h0e;
    localparam logic [5:0] IDX_CH6_MODE = 6'h0f;
    localparam logic [5:0] IDX_CH6_INT = 6'h10;
    localparam logic [5:0] IDX_CH6_FRAC = 6'h11;
    localparam logic [5:0] IDX_CH7_MODE = 6'h12;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_CH5_INT = 16'h0000;
    localparam logic [15:0] RST_CH5_FRAC = 16'h0000;
    localparam logic [15:0] RST_CH6_MODE = 16'h0000;
    localparam logic [15:0] RST_CH6_INT = 16'h0000;
    localparam logic [15:0] RST_CH6_FRAC = 16'h0000;
    localparam logic [15:0] RST_CH7_MODE = 16'h0000;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int INT_DIV_MSB = 11;
    localparam int INT_DIV_LSB = 4;
    localparam int FRAC_HI_MSB = 3;
    localparam int PRESCALE_MSB = 12;
    localparam int PRESCALE_LSB = 10;
    localparam int PATH_ON_BIT = 9;
    localparam int SLEW_BIT = 8;
    localparam int NEG_ON_BIT = 7;
    localparam int POS_ON_BIT = 6;
    localparam int DRIVER_MSB = 4;
    localparam int DRIVER_LSB = 3;
    localparam int STATE_MSB = 2;
    localparam int STATE_LSB = 1;
    localparam int SUPPLY_BIT = 0;

    // ----------------------------------------------------------------
    // Prescale codes and ratios
    // ----------------------------------------------------------------
    localparam logic [2:0] PRESCALE_DIV2 = 3'h0;
    localparam logic [2:0] PRESCALE_DIV3 = 3'h1;
    localparam logic [2:0] PRESCALE_DIV1 = 3'h7;
    localparam logic [1:0] RATIO_ONE = 2'h1;
    localparam logic [1:0] RATIO_TWO = 2'h2;
    localparam logic [1:0] RATIO_THREE = 2'h3;
    localparam logic [1:0] RATIO_NONE = 2'h0;

    // ----------------------------------------------------------------
    // Modes and carriers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ODCB_DRV_DIFF = 2'h0,
        ODCB_DRV_SINGLE = 2'h1,
        ODCB_DRV_HCSL = 2'h3
    } odcb_driver_e;

    typedef enum logic [1:0] {
        ODCB_OUT_OFF = 2'h0,
        ODCB_OUT_CLOCK = 2'h1,
        ODCB_OUT_LOW = 2'h2,
        ODCB_OUT_HIGH = 2'h3
    } odcb_out_state_e;

    typedef struct packed {
        logic [8:0] int_ratio;
        logic [19:0] fraction;
    } odcb_divider_s;

    typedef struct packed {
        odcb_divider_s div;
        logic [1:0] prescale_ratio;
        logic prescale_bypass;
        logic prescale_reserved;
        logic path_on;
        logic slew_slow;
        logic pos_on;
        logic neg_on;
        odcb_driver_e driver;
        odcb_out_state_e out_state;
        logic supply_high;
    } odcb_ch6_s;

endpackage : odcb_pkg

// file: core/odcb_bank.sv
// Wishbone register bank holding the channel 5 and channel 6 output divider settings
`timescale 1ns/100ps
`default_nettype none

module odcb_bank
    import odcb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ODCB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [ODCB_DAT_W-1:0] wb_dat_i,
    output logic [ODCB_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output odcb_divider_s ch5_cfg_o,
    output odcb_ch6_s ch6_cfg_o,
    output logic [ODCB_WORD_W-1:0] ch7_mode_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Byte-lane merge; lanes 2 and 3 carry nothing in these 16-bit words
    function automatic logic [15:0] odcb_merge(input logic [15:0] old,
                                               input logic [15:0] wdat,
                                               input logic [1:0] sel);
        odcb_merge = {sel[1] ? wdat[15:8] : old[15:8], sel[0] ? wdat[7:0] : old[7:0]};
    endfunction : odcb_merge

    // Integer field plus one, widened so a field of 8'hff gives 256
    function automatic logic [8:0] odcb_ratio(input logic [15:0] w);
        odcb_ratio = {1'b0, w[INT_DIV_MSB:INT_DIV_LSB]} + 9'h001;
    endfunction : odcb_ratio

    // Top four fraction bits from the integer word, low sixteen from the next
    function automatic logic [19:0] odcb_frac(input logic [15:0] hi, input logic [15:0] lo);
        odcb_frac = {hi[FRAC_HI_MSB:0], lo};
    endfunction : odcb_frac

    // ----------------------------------------------------------------
    // Storage and bus decode
    // ----------------------------------------------------------------
    logic [15:0] ch5_int_div_frac_high;
    logic [15:0] ch5_frac_low;
    logic [15:0] ch6_output_mode;
    logic [15:0] ch6_int_div_frac_high;
    logic [15:0] ch6_frac_low;
    logic [15:0] ch7_output_mode;
    logic [15:0] read_word;
    logic req;
    logic wr_take;
    logic [5:0] idx;

    // A request is taken once; the ack flop blocks a second take
    assign req = wb_cyc_i & wb_stb_i;
    assign idx = wb_adr_i[7:2];
    assign wr_take = req & wb_ack_o & wb_we_i;

    // Ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end

    // Read mux; unmapped indices read zero and take no write
    always_comb begin
        case (idx)
            IDX_CH5_INT: read_word = ch5_int_div_frac_high;
            IDX_CH5_FRAC: read_word = ch5_frac_low;
            IDX_CH6_MODE: read_word = ch6_output_mode;
            IDX_CH6_INT: read_word = ch6_int_div_frac_high;
            IDX_CH6_FRAC: read_word = ch6_frac_low;
            IDX_CH7_MODE: read_word = ch7_output_mode;
            default: read_word = 16'h0000;
        endcase
    end

    // Read data is captured as the ack is raised, upper half always zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req & ~wb_ack_o) begin
            wb_dat_o <= {16'h0000, read_word};
        end
    end

    // Writes land on the edge that sees ack high; full word kept as written
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ch5_int_div_frac_high <= RST_CH5_INT;
            ch5_frac_low <= RST_CH5_FRAC;
            ch6_output_mode <= RST_CH6_MODE;
            ch6_int_div_frac_high <= RST_CH6_INT;
            ch6_frac_low <= RST_CH6_FRAC;
            ch7_output_mode <= RST_CH7_MODE;
        end else if (wr_take) begin
            case (idx)
                IDX_CH5_INT: begin
                    ch5_int_div_frac_high <= odcb_merge(ch5_int_div_frac_high, wb_dat_i[15:0],
                                                        wb_sel_i[1:0]);
                end
                IDX_CH5_FRAC: begin
                    ch5_frac_low <= odcb_merge(ch5_frac_low, wb_dat_i[15:0], wb_sel_i[1:0]);
                end
                IDX_CH6_MODE: begin
                    ch6_output_mode <= odcb_merge(ch6_output_mode, wb_dat_i[15:0], wb_sel_i[1:0]);
                end
                IDX_CH6_INT: begin
                    ch6_int_div_frac_high <= odcb_merge(ch6_int_div_frac_high, wb_dat_i[15:0],
                                                        wb_sel_i[1:0]);
                end
                IDX_CH6_FRAC: begin
                    ch6_frac_low <= odcb_merge(ch6_frac_low, wb_dat_i[15:0], wb_sel_i[1:0]);
                end
                IDX_CH7_MODE: begin
                    ch7_output_mode <= odcb_merge(ch7_output_mode, wb_dat_i[15:0], wb_sel_i[1:0]);
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Field decode toward the divider and driver logic
    // ----------------------------------------------------------------
    // Registered so the divider sees settled settings one cycle after a write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ch5_cfg_o <= '0;
        end else begin
            ch5_cfg_o.int_ratio <= odcb_ratio(ch5_int_div_frac_high);
            ch5_cfg_o.fraction <= odcb_frac(ch5_int_div_frac_high, ch5_frac_low);
        end
    end

    // Channel 6; negative-side enable is passed as written, software keeps it paired
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ch6_cfg_o <= '0;
            ch7_mode_o <= RST_CH7_MODE;
        end else begin
            ch6_cfg_o.div.int_ratio <= odcb_ratio(ch6_int_div_frac_high);
            ch6_cfg_o.div.fraction <= odcb_frac(ch6_int_div_frac_high, ch6_frac_low);
            ch6_cfg_o.path_on <= ch6_output_mode[PATH_ON_BIT];
            ch6_cfg_o.slew_slow <= ch6_output_mode[SLEW_BIT];
            ch6_cfg_o.pos_on <= ch6_output_mode[POS_ON_BIT];
            ch6_cfg_o.neg_on <= ch6_output_mode[NEG_ON_BIT];
            ch6_cfg_o.supply_high <= ch6_output_mode[SUPPLY_BIT];
            ch6_cfg_o.out_state <= odcb_out_state_e'(ch6_output_mode[STATE_MSB:STATE_LSB]);
            ch7_mode_o <= ch7_output_mode;
            // Both low codes choose the differential driver
            case (ch6_output_mode[DRIVER_MSB:DRIVER_LSB])
                2'h2: ch6_cfg_o.driver <= ODCB_DRV_SINGLE;
                2'h3: ch6_cfg_o.driver <= ODCB_DRV_HCSL;
                default: ch6_cfg_o.driver <= ODCB_DRV_DIFF;
            endcase
            // Path off bypasses the prescaler; a reserved code is flagged, not guessed
            if (!ch6_output_mode[PATH_ON_BIT]) begin
                ch6_cfg_o.prescale_bypass <= 1'b1;
                ch6_cfg_o.prescale_ratio <= RATIO_ONE;
                ch6_cfg_o.prescale_reserved <= 1'b0;
            end else begin
                ch6_cfg_o.prescale_bypass <= 1'b0;
                case (ch6_output_mode[PRESCALE_MSB:PRESCALE_LSB])
                    PRESCALE_DIV2: begin
                        ch6_cfg_o.prescale_ratio <= RATIO_TWO;
                        ch6_cfg_o.prescale_reserved <= 1'b0;
                    end
                    PRESCALE_DIV3: begin
                        ch6_cfg_o.prescale_ratio <= RATIO_THREE;
                        ch6_cfg_o.prescale_reserved <= 1'b0;
                    end
                    PRESCALE_DIV1: begin
                        ch6_cfg_o.prescale_ratio <= RATIO_ONE;
                        ch6_cfg_o.prescale_reserved <= 1'b0;
                    end
                    default: begin
                        ch6_cfg_o.prescale_ratio <= RATIO_NONE;
                        ch6_cfg_o.prescale_reserved <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence mode_write_s;
        wr_take && idx == IDX_CH6_MODE && wb_sel_i[1] && wb_sel_i[0];
    endsequence

    sequence path_on_write_s;
        mode_write_s ##0 wb_dat_i[PATH_ON_BIT];
    endsequence

    sequence path_off_write_s;
        mode_write_s ##0 !wb_dat_i[PATH_ON_BIT];
    endsequence

    ack_single_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held for more than one cycle");

    ack_latency_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_ack_o |=> wb_ack_o)
        else $error("Ack not given one cycle after request");

    int_ratio_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> ch5_cfg_o.int_ratio ==
            {1'b0, $past(ch5_int_div_frac_high[11:4])} + 9'h001)
        else $error("Channel 5 ratio is not field plus one");

    frac_join_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> ch6_cfg_o.div.fraction == {$past(ch6_int_div_frac_high[3:0]),
                                                   $past(ch6_frac_low)})
        else $error("Channel 6 fraction not joined correctly");

    prescale_div3_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ch6_output_mode[12:10] == 3'h1 && ch6_output_mode[9] |=> ch6_cfg_o.prescale_ratio == 2'h3)
        else $error("Prescale code 001 did not give three");

    prescale_bypass_a: assert property (@(posedge clk_i) disable iff (rst_i)
        path_off_write_s |-> ##2 ch6_cfg_o.prescale_bypass && ch6_cfg_o.prescale_ratio == 2'h1)
        else $error("Prescaler not bypassed with path off");

    path_on_seen_a: assert property (@(posedge clk_i) disable iff (rst_i)
        path_on_write_s |-> ##2 ch6_cfg_o.path_on && !ch6_cfg_o.prescale_bypass)
        else $error("Fraction path enable not applied");

    slew_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_write_s |-> ##2 ch6_cfg_o.slew_slow == $past(wb_dat_i[8], 2))
        else $error("Slew bit not applied");

    side_enables_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_write_s |-> ##2 {ch6_cfg_o.neg_on, ch6_cfg_o.pos_on} == $past(wb_dat_i[7:6], 2))
        else $error("Single-ended side enables not applied");

    driver_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ch6_output_mode[4:3] == 2'h2 |=> ch6_cfg_o.driver == ODCB_DRV_SINGLE)
        else $error("Driver code 10 did not pick single-ended");

    out_state_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ch6_output_mode[2:1] == 2'h2 |=> ch6_cfg_o.out_state == ODCB_OUT_LOW)
        else $error("Output code 10 did not force low");

    supply_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_write_s |-> ##2 ch6_cfg_o.supply_high == $past(wb_dat_i[0], 2))
        else $error("Supply select not applied");

    readback_word_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_ack_o && !wb_we_i && idx == IDX_CH5_FRAC
        |=> wb_dat_o == {16'h0000, $past(ch5_frac_low)})
        else $error("Read-back does not match stored word");

    // Channel 6 ratio and channel 5 fraction, then per-code decode checks so no broken case item hides; then write landing, unmapped read, channel 7 copy
    ch6_ratio_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> ch6_cfg_o.div.int_ratio ==
            {1'b0, $past(ch6_int_div_frac_high[11:4])} + 9'h001)
        else $error("Channel 6 ratio is not field plus one");

    ch5_frac_join_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> ch5_cfg_o.fraction == {$past(ch5_int_div_frac_high[3:0]),
                                                 $past(ch5_frac_low)})
        else $error("Channel 5 fraction not joined correctly");

    prescale_div2_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ch6_output_mode[12:10] == 3'h0 && ch6_output_mode[9] |=> ch6_cfg_o.prescale_ratio == 2'h2)
        else $error("Prescale code 000 did not give two");

    prescale_div1_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ch6_output_mode[12:10] == 3'h7 && ch6_output_mode[9] |=> ch6_cfg_o.prescale_ratio == 2'h1)
        else $error("Prescale code 111 did not give one");

    prescale_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ch6_output_mode[9] && ch6_output_mode[12:10] inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h6}
        |=> ch6_cfg_o.prescale_reserved && ch6_cfg_o.prescale_ratio == 2'h0)
        else $error("Reserved prescale code not flagged");

    bypass_any_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ch6_output_mode[9] |=> ch6_cfg_o.prescale_bypass && !ch6_cfg_o.prescale_reserved)
        else $error("Prescale code used while path is off");

    driver_hcsl_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ch6_output_mode[4:3] == 2'h3 |=> ch6_cfg_o.driver == ODCB_DRV_HCSL)
        else $error("Driver code 11 did not pick HCSL");

    driver_diff_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ch6_output_mode[4] |=> ch6_cfg_o.driver == ODCB_DRV_DIFF)
        else $error("Low driver codes did not pick differential");

    out_state_all_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> ch6_cfg_o.out_state == $past(ch6_output_mode[2:1]))
        else $error("Output state does not follow its field");

    write_lands_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && idx == IDX_CH5_FRAC && wb_sel_i[1:0] == 2'h3
        |=> ch5_frac_low == $past(wb_dat_i[15:0]))
        else $error("Full-word write did not land");

    unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_ack_o && !wb_we_i && idx == 6'h00 |=> wb_dat_o == 32'h0000_0000)
        else $error("Unmapped read did not return zero");

    ch7_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> ch7_mode_o == $past(ch7_output_mode))
        else $error("Channel 7 mode copy is stale");

endmodule : odcb_bank

`default_nettype wire

// file: verification/output_divider_config_bank_test.sv
// Self-checking testbench for the output divider configuration bank
`timescale 1ns/100ps
`default_nettype none

module output_divider_config_bank_test;
    import odcb_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus and observation signals
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [ODCB_ADR_W-1:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [ODCB_DAT_W-1:0] wb_dat_i = 32'h0000_0000;
    logic [ODCB_DAT_W-1:0] wb_dat_o;
    logic wb_ack_o;
    odcb_divider_s ch5_cfg_o;
    odcb_ch6_s ch6_cfg_o;
    logic [ODCB_WORD_W-1:0] ch7_mode_o;
    logic [15:0] sh [6];
    logic [31:0] exp_q [$];
    int n_fail = 0;
    int comparisons = 0;

    // ----------------------------------------------------------------
    // Clock and design
    // ----------------------------------------------------------------
    // Half period of 5 ns gives 100 MHz
    always #5 clk_i = ~clk_i;

    odcb_bank DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ch5_cfg_o(ch5_cfg_o),
        .ch6_cfg_o(ch6_cfg_o), .ch7_mode_o(ch7_mode_o));

    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic results();
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // Read data is judged at the very edge where the master sees ack
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_q.size() == 0) begin
                check(wb_dat_o, 32'hdead_beef);
            end else begin
                check(wb_dat_o, exp_q.pop_front());
            end
        end
    end

    // Hang guard; the whole run needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        results();
    end

    // ----------------------------------------------------------------
    // Bus cycle: request held until ack is sampled, then one idle cycle
    // ----------------------------------------------------------------
    task automatic wb_cycle(input logic we, input logic [5:0] idx, input logic [15:0] d,
        input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'h0};
        wb_sel_i <= sel;
        wb_dat_i <= {16'h0000, d};
        // No cap here: only the watchdog ends a wait, ack is due on the second edge
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        check(32'(n), 32'h2);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb_cycle

    // Write one word and keep the shadow copy the checks work from
    task automatic wr(input int k, input logic [15:0] d);
        sh[k] = d;
        wb_cycle(1'b1, IDX_CH5_INT + 6'(k), d, 4'h3);
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic [15:0] want);
        exp_q.push_back({16'h0000, want});
        wb_cycle(1'b0, idx, 16'h0000, 4'h3);
    endtask : rd

    // Decoded outputs worked out from the shadow words
    task automatic check_cfg();
        logic [15:0] m;
        logic [1:0] ratio;
        logic [1:0] drv;
        @(posedge clk_i);
        #1;
        m = sh[2];
        if (!m[9]) ratio = RATIO_ONE;
        else if (m[12:10] == PRESCALE_DIV2) ratio = RATIO_TWO;
        else if (m[12:10] == PRESCALE_DIV3) ratio = RATIO_THREE;
        else if (m[12:10] == PRESCALE_DIV1) ratio = RATIO_ONE;
        else ratio = RATIO_NONE;
        drv = (m[4:3] == 2'h3) ? 2'h3 : (m[4:3] == 2'h2) ? 2'h1 : 2'h0;
        check(ch5_cfg_o.int_ratio, {1'b0, sh[0][11:4]} + 9'h001);
        check(ch5_cfg_o.fraction, {sh[0][3:0], sh[1]});
        check(ch6_cfg_o.div.int_ratio, {1'b0, sh[3][11:4]} + 9'h001);
        check(ch6_cfg_o.div.fraction, {sh[3][3:0], sh[4]});
        check(ch6_cfg_o.prescale_ratio, ratio);
        check(ch6_cfg_o.prescale_bypass, !m[9]);
        check(ch6_cfg_o.prescale_reserved, ratio == RATIO_NONE);
        check(ch6_cfg_o.path_on, m[9]);
        check(ch6_cfg_o.slew_slow, m[8]);
        check({ch6_cfg_o.neg_on, ch6_cfg_o.pos_on}, m[7:6]);
        check(ch6_cfg_o.driver, drv);
        check(ch6_cfg_o.out_state, m[2:1]);
        check(ch6_cfg_o.supply_high, m[0]);
        check(ch7_mode_o, sh[5]);
    endtask : check_cfg

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] m;
        void'($urandom(32'h245f71cd));
        for (int k = 0; k < 6; k++) sh[k] = 16'h0000;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset state: all words zero, ratios decode to one
        check_cfg();
        for (int k = 0; k < 6; k++) rd(IDX_CH5_INT + 6'(k), 16'h0000);
        // Integer divider boundaries and fraction joined across two words
        wr(0, 16'h0ff5);
        wr(1, 16'ha5c3);
        check_cfg();
        wr(0, 16'h0000);
        wr(3, 16'h0ff0);
        wr(4, 16'hffff);
        check_cfg();
        // Every prescale code with the path on and off, all drivers and states
        for (int i = 0; i < 32; i++) begin
            m = 16'($urandom()) & 16'h01dd;
            m[7] = m[7] & m[6];
            m[12:10] = i[2:0];
            m[9] = i[3];
            m[4:3] = i[1:0];
            m[2:1] = i[3:2];
            m[0] = i[4];
            wr(2, m);
            check_cfg();
        end
        // Random words with reserved bits zero, read back in reverse order
        for (int i = 0; i < 12; i++) begin
            wr(0, 16'($urandom()) & 16'h0fff);
            wr(1, 16'($urandom()));
            wr(3, 16'($urandom()) & 16'h0fff);
            wr(4, 16'($urandom()));
            wr(5, 16'($urandom()) & 16'h1fdf);
            check_cfg();
            for (int k = 5; k >= 0; k--) rd(IDX_CH5_INT + 6'(k), sh[k]);
        end
        // Low byte enable only touches bits 7:0
        wr(4, 16'h0000);
        sh[4] = 16'h00ff;
        wb_cycle(1'b1, IDX_CH6_FRAC, 16'hffff, 4'h1);
        rd(IDX_CH6_FRAC, 16'h00ff);
        // Unmapped places answer with zero and drop writes
        wb_cycle(1'b1, 6'h00, 16'h1234, 4'h3);
        wb_cycle(1'b1, 6'h13, 16'h5678, 4'h3);
        rd(6'h00, 16'h0000);
        rd(6'h13, 16'h0000);
        check_cfg();
        // Second reset in mid-run clears every word
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 6; k++) sh[k] = 16'h0000;
        check_cfg();
        rd(IDX_CH6_MODE, 16'h0000);
        repeat (4) @(posedge clk_i);
        if (exp_q.size() != 0) check(32'(exp_q.size()), 32'h0);
        results();
    end

endmodule : output_divider_config_bank_test

`default_nettype wire
